// ==== pnf_consts.svh ====
/*
  constants for the network receive filter: register offsets, field
  positions, reset values and mode codes. assumes inclusion by bare name.
*/
`ifndef PNF_CONSTS_SVH
`define PNF_CONSTS_SVH

// register offsets (word index on the plain register port)
`define A_FD_CONTROL_HIGH 4'h0
`define A_FD_STATUS_LOW   4'h1
`define A_RULE_COUNT      4'h2
`define A_ID_BASE         4'h4
`define A_PLD_BASE        4'h8
// field positions inside fd_control_high_reg
`define F_MODE_LO        0
`define F_RET_LO         2
`define F_AFL_STOP       4
// sizes and limits
`define MODE_W           2
`define RULES            2
`define RULE_CNT_MAX     2'h2
`define MIN_DLC          4'h4
`define WORD_BYTES       7'h04
// top bit of a rule image that survives one 32-bit shift-in step
`define RULE_KEEP_HI     195
// state codes
`define ST_AFL           2'h0
`define ST_ID_AFL        2'h1
`define ST_PLD_AFL       2'h2
`define ST_WAKE          2'h3
// reset values
`define RST_CTRL         5'h00
`define RST_CNT          2'h0

`endif

// ==== pnf_pkg.sv ====
/*
  types for the network receive filter: frame carrier, rule layout,
  decision carrier and state enum. assumes nothing else.
*/
package pnf_pkg;

  typedef enum logic [1:0] {
    ST_AFL_ONLY = 2'b00,
    ST_ID_AFL   = 2'b01,
    ST_PLD_AFL  = 2'b10,
    ST_WAKE     = 2'b11
  } filt_state_e;

  // received frame, delivered by the protocol receive path
  typedef struct packed {
    logic         valid;
    logic         ide;
    logic         rtr;
    logic [28:0]  id;
    logic [3:0]   dlc;
    logic [6:0]   len;      // payload length in bytes, 0..64
    logic [511:0] data;     // byte 0 in bits 7:0
    logic         afl_hit;  // acceptance list result from outside
    logic [15:0]  afl_ptr;
    logic [4:0]   afl_dest;
  } frame_s;

  typedef struct packed {
    logic         store;
    logic         by_net;
    logic [15:0]  ptr;
    logic [4:0]   dest;
  } verdict_s;

  // one network rule: id part and payload part
  typedef struct packed {
    logic         ide;
    logic         rtr;
    logic [28:0]  id;
    logic         ide_m;
    logic         rtr_m;
    logic [28:0]  id_m;
    logic [3:0]   dlc;
    logic [15:0]  ptr;
    logic [4:0]   dest;
    logic         and_or;   // 0 = and, 1 = or
    logic [1:0]   rng;      // per filter: range mode
    logic [1:0]   outside;  // per filter: outside limits passes
    logic [3:0]   off0;
    logic [3:0]   off1;
    logic [31:0]  d0;       // match data or upper limit
    logic [31:0]  m0;       // match mask or lower limit
    logic [31:0]  d1;
    logic [31:0]  m1;
  } rule_s;

  typedef struct packed {
    filt_state_e   state;
    logic [1:0]    mode_ctl;
    logic [1:0]    ret_sel;
    logic          afl_stop;
    logic [1:0]    rule_cnt;
    rule_s [1:0]   rule;
    verdict_s      verdict;
    logic          verdict_v;
    logic [31:0]   rdata;
  } regs_s;

endpackage : pnf_pkg

// ==== pretended_network_receive_filter.sv ====
/*
  pretended network receive filter: decides per received frame whether it
  is stored and under which rule, and tracks the filter operating state.
  assumes a plain register port with one-cycle strobes, read data in the
  next cycle, and a receive path that offers one decoded frame per valid.
*/
`include "pnf_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module pretended_network_receive_filter
  import pnf_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [7:0]   addr,
  input  wire logic [31:0]  wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [31:0]  rdata,
  input  wire frame_s       frame,
  output var verdict_s      verdict,
  output logic              verdict_valid,
  output logic      [1:0]   filter_state_status
);

  regs_s q, d;

  // the 32-bit payload word at a word offset, little-endian bytes
  function automatic logic [31:0] pick_word(input logic [511:0] data,
                                            input logic [3:0] off);
    pick_word = data[{off, 5'h00} +: 32];
  endfunction : pick_word

  // one payload filter; short payloads fail it
  function automatic logic pld_pass(input frame_s f, input logic [3:0] off,
                                    input logic rng, input logic outside,
                                    input logic [31:0] dat,
                                    input logic [31:0] msk);
    logic [31:0] v;
    logic        in_rng;
    v      = pick_word(f.data, off);
    in_rng = (v >= msk) && (v <= dat);
    if ({1'b0, f.len} < ({1'b0, off, 2'b00} + {1'b0, `WORD_BYTES}))
      pld_pass = 1'b0;
    else if (rng)
      pld_pass = outside ? !in_rng : in_rng;
    else
      pld_pass = ((v ^ dat) & msk) == 32'h0000_0000;
  endfunction : pld_pass

  // id filter of one rule: ide, rtr and id under their masks; the dlc check is separate
  function automatic logic id_hit(input frame_s f, input rule_s r);
    id_hit = (((f.ide ^ r.ide) & r.ide_m) == 1'b0) &&
             (((f.rtr ^ r.rtr) & r.rtr_m) == 1'b0) &&
             (((f.id ^ r.id) & r.id_m) == 29'h0);
  endfunction : id_hit

  // register reads decode; unmapped addresses read as zero
  function automatic logic [31:0] reg_read(input regs_s s, input logic [7:0] a);
    logic [3:0] idx;
    idx      = a[3:0];
    reg_read = 32'h0000_0000;
    if (a[7:4] != 4'h0)
      reg_read = 32'h0000_0000;
    else if (idx == `A_FD_CONTROL_HIGH)
      reg_read = {27'h0, s.afl_stop, s.ret_sel, s.mode_ctl};
    else if (idx == `A_FD_STATUS_LOW)
      reg_read = {30'h0, s.state};
    else if (idx == `A_RULE_COUNT)
      reg_read = {30'h0, s.rule_cnt};
  endfunction : reg_read

  logic        hit0, hit1, any_hit, sel, pass, dlc_ok, pld_ok;
  logic        sel_f0, sel_f1;
  rule_s       r;

  // frame decision and state update
  always_comb begin
    d           = q;
    d.verdict_v = 1'b0;
    d.verdict   = '0;
    d.rdata     = rd ? reg_read(q, addr) : 32'h0000_0000;
    // rules beyond the configured count are not checked
    hit0    = (q.rule_cnt != `RST_CNT) && id_hit(frame, q.rule[0]);
    hit1    = (q.rule_cnt == `RULE_CNT_MAX) && id_hit(frame, q.rule[1]);
    any_hit = hit0 || hit1;
    sel     = !hit0;
    r       = q.rule[sel];
    dlc_ok  = (r.dlc == 4'h0) || (frame.dlc >= r.dlc);
    sel_f0  = pld_pass(frame, r.off0, r.rng[0], r.outside[0], r.d0, r.m0);
    sel_f1  = pld_pass(frame, r.off1, r.rng[1], r.outside[1], r.d1, r.m1);
    pld_ok  = r.and_or ? (sel_f0 || sel_f1) : (sel_f0 && sel_f1);
    if (frame.rtr || frame.dlc < `MIN_DLC)
      pld_ok = 1'b0;
    pass = any_hit && dlc_ok && pld_ok;
    if (frame.valid) begin
      d.verdict_v = 1'b1;
      unique case (q.state)
        ST_AFL_ONLY: begin
          d.verdict.store = frame.afl_hit;
        end
        ST_ID_AFL: begin
          if (any_hit) begin
            d.verdict.store  = dlc_ok;
            d.verdict.by_net = 1'b1;
          end else
            d.verdict.store = frame.afl_hit && !q.afl_stop;
        end
        ST_PLD_AFL: begin
          if (any_hit) begin
            d.verdict.store  = pass;
            d.verdict.by_net = 1'b1;
          end else
            d.verdict.store = frame.afl_hit && !q.afl_stop;
        end
        ST_WAKE: begin
          d.verdict.store  = pass;
          d.verdict.by_net = any_hit;
          if (pass)
            d.state = filt_state_e'(q.ret_sel);
        end
      endcase
      if (d.verdict.by_net) begin
        d.verdict.ptr  = r.ptr;
        d.verdict.dest = r.dest;
      end else if (d.verdict.store) begin
        d.verdict.ptr  = frame.afl_ptr;
        d.verdict.dest = frame.afl_dest;
      end
    end
    // software writes; a mode write takes precedence over the auto return
    if (wr && addr[7:4] == 4'h0) begin
      if (addr[3:0] == `A_FD_CONTROL_HIGH) begin
        d.mode_ctl = wdata[`F_MODE_LO +: `MODE_W];
        d.ret_sel  = wdata[`F_RET_LO +: `MODE_W];
        d.afl_stop = wdata[`F_AFL_STOP];
        d.state    = filt_state_e'(wdata[`F_MODE_LO +: `MODE_W]);
      end else if (addr[3:0] == `A_RULE_COUNT) begin
        d.rule_cnt = (wdata[1:0] > `RULE_CNT_MAX) ? `RULE_CNT_MAX : wdata[1:0];
      end
    end
    // a rule is too wide for one port word, so each write shifts the
    // word into the low end of the image; the oldest bits fall off the top
    if (wr && addr[7:4] == 4'h1) begin
      d.rule[addr[3]] = rule_s'({q.rule[addr[3]][`RULE_KEEP_HI:0], wdata});
    end
  end

  // registered state; reset lands in acceptance-only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q          <= '0;
      q.state    <= ST_AFL_ONLY;
      q.mode_ctl <= 2'h0;
      q.rule_cnt <= `RST_CNT;
    end else begin
      q <= d;
    end
  end

  assign rdata               = q.rdata;
  assign verdict             = q.verdict;
  assign verdict_valid       = q.verdict_v;
  assign filter_state_status = q.state;

endmodule : pretended_network_receive_filter

`default_nettype wire

// ==== pnf_assertions.sv ====
/* port checker for the receive filter, bound to its top.
   assumes one clock and an active-high async reset. */
`timescale 1ns/1ns
`default_nettype none
module pnf_assertions
  import pnf_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire frame_s      frame,
  input wire verdict_s    verdict,
  input wire logic        verdict_valid,
  input wire logic [1:0]  filter_state_status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic       mode_wr;
  logic [1:0] st;
  // a mode write is the only cause of a state change apart from frames
  assign mode_wr = wr && addr == 8'h00;
  assign st = filter_state_status;
  reset_state_a: assert property ($fell(rst) |-> st == 2'h0 && !verdict_valid)
    else $error("bad state after reset");
  mode_write_a: assert property (mode_wr |=> st == $past(wdata[1:0]))
    else $error("mode write lost");
  state_hold_a: assert property (!mode_wr && !frame.valid |=> $stable(st))
    else $error("state moved");
  vv_follow_a: assert property (frame.valid |=> verdict_valid)
    else $error("no verdict");
  vv_cause_a: assert property (verdict_valid |-> $past(frame.valid))
    else $error("stray verdict");
  rd_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside slot");
  afl_only_a: assert property (frame.valid && st == 2'h0 |=>
    verdict.store == $past(frame.afl_hit) && !verdict.by_net)
    else $error("state 00 verdict");
  wake_no_afl_a: assert property (frame.valid && st == 2'h3 |=> !verdict.store || verdict.by_net)
    else $error("list stored in wake");
  short_fail_a: assert property (frame.valid && st == 2'h3 && (frame.rtr || frame.dlc < 4'h4)
    |=> !verdict.store)
    else $error("short frame stored");
  cover property (frame.valid && st == 2'h3 ##1 verdict.store);
  cover property (verdict_valid && verdict.by_net);
  cover property (mode_wr);
endmodule : pnf_assertions
bind pretended_network_receive_filter pnf_assertions u_chk (.clk, .rst, .addr, .wdata, .wr,
  .rd, .rdata, .frame, .verdict, .verdict_valid, .filter_state_status);
`default_nettype wire

// ==== pnf_rx_model.sv ====
/* stand-in for the protocol receive path: one frame, one cycle, per go.
   assumes the bench fills every field but valid and len. */
`timescale 1ns/1ns
`default_nettype none
module pnf_rx_model
  import pnf_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   go,
  input  wire frame_s fin,
  output var frame_s  frame
);
  logic [6:0] lut [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 12, 16, 20, 24, 32, 48, 64};
  initial frame = '0;
  // payload toggles between frames so stale data never looks valid
  always @(posedge clk) begin
    if (go) begin
      frame <= fin;
      frame.len <= lut[fin.dlc];
      frame.valid <= 1'b1;
    end else begin
      frame.valid <= 1'b0;
      frame.data <= ~frame.data;
    end
  end
endmodule : pnf_rx_model
`default_nettype wire

// ==== test_pretended_network_receive_filter.sv ====
/* queue-scored bench for the receive filter: registers, rules, frames in
   all four states. assumes the frame source model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module test_pretended_network_receive_filter
  import pnf_pkg::*;
;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, go = 0, rd_p = 0, verdict_valid;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, exp_v, act_v, expq [$];
  logic [1:0]  filter_state_status;
  frame_s      fin = '0, frame;
  verdict_s    verdict;
  rule_s       r;
  int          mismatches = 0, checked = 0;
  always #5 clk = ~clk;
  pretended_network_receive_filter DUT (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .frame, .verdict, .verdict_valid, .filter_state_status);
  pnf_rx_model u_src (.clk, .go, .fin, .frame);
  task automatic conclude();
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  // rule image goes in most significant word first
  task automatic load(input int j);
    logic [671:0] img;
    img = 672'(r);
    for (int k = 0; k < 21; k++) wreg(8'(8'h10 + j * 8), 32'(img >> (32 * (20 - k))));
  endtask : load
  // kinds: 0 miss, 1 list hit, 2 bad byte, 3 remote, 4 dlc 3, 5 dlc 4, 6 pass
  task automatic send(input logic [1:0] m, input int k, input logic stop, input logic orx);
    logic        hit, pass, acceptance_list;
    logic [31:0] e, net, lst;
    frame_s      f;
    f = '0;
    for (int i = 0; i < 16; i++) f.data[i * 32 +: 32] = $urandom;
    hit = k >= 2;
    pass = k == 6 || (orx && k == 5);
    acceptance_list = k != 0;
    f.afl_ptr = 16'($urandom);
    f.afl_dest = 5'($urandom);
    f.rtr = k == 3;
    f.id = hit ? 29'h120 : 29'h155;
    f.dlc = k == 4 ? 4'h3 : k == 5 ? 4'h4 : 4'h8;
    f.data[63:32] = 32'h000003e8;
    f.data[15:12] = 4'hb;
    f.data[7:0] = k == 2 ? 8'h07 : 8'h06;
    f.afl_hit = acceptance_list;
    net = 32'h00070010;
    lst = {9'h0, f.afl_dest, 2'b10, f.afl_ptr};
    if (m == 2'h0) e = acceptance_list ? lst : 32'h0;
    else if (hit) e = (m == 2'h1 || pass) ? net : 32'h0;
    else e = (m != 2'h3 && acceptance_list && !stop) ? lst : 32'h0;
    @(posedge clk);
    fin <= f;
    go <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    go <= 1'b0;
  endtask : send
  // scoreboard: oldest note against each read or verdict
  always @(posedge clk) begin
    if (rd_p || verdict_valid) begin
      act_v = rd_p ? rdata : {9'h0, verdict.store ? verdict.dest : 5'h00, verdict.store,
        verdict.store & verdict.by_net, verdict.store ? verdict.ptr : 16'h0};
      exp_v = expq.size() > 0 ? expq.pop_front() : 32'hffffffff;
      checked++;
      if (act_v !== exp_v) begin
        mismatches++;
        $display("BAD t=%0t got %h exp %h", $time, act_v, exp_v);
      end
    end
    rd_p <= rd;
  end
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  initial begin
    void'($urandom(86));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rreg(8'h01, 32'h0);
    wreg(8'h02, 32'h3);
    rreg(8'h02, 32'h2);
    rreg(8'h07, 32'h0);
    r = '0;
    r.id = 29'h120;
    r.ide_m = 1'b1;
    r.rtr_m = 1'b0; // remote frames must still hit the id stage
    r.dest = 5'h01;
    r.id_m = '1;
    r.rng = 2'b10;
    r.off1 = 4'h1;
    r.d0 = 32'h0000b006;
    r.m0 = 32'h0000f0ff;
    r.d1 = 32'd2000;
    r.m1 = 32'd500;
    r.ptr = 16'h0010;
    load(0);
    r.ptr = 16'h0020;
    load(1);
    for (int m = 0; m < 4; m++) begin
      wreg(8'h00, {27'h0, 3'h2, 2'(m)});
      rreg(8'h01, 32'(m));
      for (int k = 0; k < 7; k++) send(2'(m), k, 1'b0, 1'b0);
    end
    rreg(8'h01, 32'h2);
    r.ptr = 16'h0010;
    r.and_or = 1'b1;
    r.outside = 2'b10;
    load(0);
    for (int k = 0; k < 7; k++) send(2'h2, k, 1'b0, 1'b1);
    wreg(8'h00, 32'h11);
    send(2'h1, 1, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule : test_pretended_network_receive_filter
`default_nettype wire
